// *** hw/pmo_port.v ***
`timescale 1ns/1ns
`include "pmo_regs.vh"
module pmo_port #(
    parameter CODE_W = `PMO_CODE_W                        // Bits in one code word
) (
    input  wire                         clock,         // System clock
    input  wire                         arst_n,        // Async reset, active low
    input  wire                         blk_valid,     // Block offered
    input  wire [`PMO_SLOTS-1:0]        blk_used,      // Slots commanded in block
    input  wire [`PMO_SLOTS*CODE_W-1:0] blk_codes,     // Slot i in word i
    output reg                          blk_ready,     // Block taken this cycle
    output reg                          blk_error,     // Last block had out-of-range code
    output reg  [CODE_W-1:0]            code1_word,    // Slot one code
    output reg  [CODE_W-1:0]            code2_word,    // Slot two code
    output reg  [CODE_W-1:0]            code3_word,    // Slot three code
    output reg  [CODE_W-1:0]            code4_word,    // Slot four code
    output reg  [CODE_W-1:0]            code5_word,    // Slot five code
    output reg                          code1_strobe,  // Slot one strobe
    output reg                          code2_strobe,  // Slot two strobe
    output reg                          code3_strobe,  // Slot three strobe
    output reg                          code4_strobe,  // Slot four strobe
    output reg                          code5_strobe,  // Slot five strobe
    input  wire                         ops_complete,  // Shared completion from far side
    output reg                          busy           // Block in progress
);
    // Sequencer states
    localparam [1:0] ST_IDLE = `PMO_ST_IDLE;  // Waiting for a block
    localparam [1:0] ST_WAIT = `PMO_ST_WAIT;  // Strobes out, completion awaited
    localparam [1:0] ST_DROP = `PMO_ST_DROP;  // Completion must fall again

    // Sequencer and slot decode
    reg  [1:0]            state_q;     // Sequencer state
    reg  [1:0]            state_d;     // Next sequencer state
    wire [`PMO_SLOTS-1:0] ok;          // Slot range check results
    wire [`PMO_SLOTS-1:0] sub;         // Slot subprogram flags
    wire [`PMO_SLOTS-1:0] send;        // Slots to strobe
    wire                  bad;         // Any used slot out of range
    wire                  take;        // Block accepted at this edge
    wire                  finish;      // Completion seen while waiting

    // Pick one code word out of the packed block
    function [CODE_W-1:0] slot_word;
        input [`PMO_SLOTS*CODE_W-1:0] codes;  // Packed block
        input integer                 idx;    // Slot index from zero
        begin
            slot_word = codes[idx*CODE_W +: CODE_W];
        end
    endfunction

    // Magnitude limit: wide first slot, narrow others
    function [CODE_W-1:0] slot_limit;
        input integer idx;                    // Slot index from zero
        begin
            if (idx == 0) begin
                slot_limit = `PMO_MAX_SLOT1;
            end else begin
                slot_limit = `PMO_MAX_SLOTN;
            end
        end
    endfunction

    // Per-slot checks, one judge per code slot
    genvar i;
    generate
        for (i = 0; i < `PMO_SLOTS; i = i + 1) begin : g_chk
            // Range and subprogram judge for slot i
            pmo_slot_check #(
                .CODE_W     (CODE_W)
            ) u_chk (
                .code       (slot_word(blk_codes, i)),
                .max_mag    (slot_limit(i)),
                .in_range   (ok[i]),
                .is_subprog (sub[i])
            );
        end
    endgenerate

    // Subprogram codes are consumed here, never strobed
    assign send   = blk_used & ~sub;
    // One bad magnitude rejects the whole block
    assign bad    = |(blk_used & ~ok);
    // Ready gates a retake while the source still holds valid
    assign take   = (state_q == ST_IDLE) && blk_valid && !blk_ready;
    // Completion only counts while strobes stand
    assign finish = (state_q == ST_WAIT) && ops_complete;

    // Next state; completion is a level handshake,
    // so it must be seen high, then low, before the next block
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // Blocks with nothing to strobe stay idle
                if (take && !bad && (send != {`PMO_SLOTS{1'b0}})) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Far side reports all strobed work done
                if (finish) begin
                    state_d = ST_DROP;
                end
            end
            ST_DROP: begin
                // Stale completion must not end the next block
                if (!ops_complete) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                // Unused code falls back to idle
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer state register
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // Nothing in progress after reset
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Acknowledge pulse, error flag and busy level
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // Quiet handshake after reset
            blk_ready <= 1'b0;
            blk_error <= 1'b0;
            busy      <= 1'b0;
        end else begin
            // Ready is a one-cycle pulse per taken block
            blk_ready <= take;
            if (take) begin
                // Error reports the block just taken
                blk_error <= bad;
            end
            // Busy follows the sequencer's next state
            busy <= (state_d != ST_IDLE);
        end
    end

    // Code words: load issued slots, hold the rest
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // Words start cleared
            code1_word <= {CODE_W{1'b0}};
            code2_word <= {CODE_W{1'b0}};
            code3_word <= {CODE_W{1'b0}};
            code4_word <= {CODE_W{1'b0}};
            code5_word <= {CODE_W{1'b0}};
        end else if (take && !bad) begin
            // All slots of the block land on one edge
            // Slot one
            if (send[0]) begin
                code1_word <= slot_word(blk_codes, 0);
            end
            // Slot two
            if (send[1]) begin
                code2_word <= slot_word(blk_codes, 1);
            end
            // Slot three
            if (send[2]) begin
                code3_word <= slot_word(blk_codes, 2);
            end
            // Slot four
            if (send[3]) begin
                code4_word <= slot_word(blk_codes, 3);
            end
            // Slot five
            if (send[4]) begin
                code5_word <= slot_word(blk_codes, 4);
            end
        end
    end

    // Strobes: raised on take, dropped when completion arrives.
    // They stand as levels, so the far side may sample at leisure;
    // a slot not commanded in this block keeps its strobe low.
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            // No strobe after reset
            code1_strobe <= 1'b0;
            code2_strobe <= 1'b0;
            code3_strobe <= 1'b0;
            code4_strobe <= 1'b0;
            code5_strobe <= 1'b0;
        end else if (take && !bad) begin
            // Only slots commanded and not consumed here
            code1_strobe <= send[0];
            code2_strobe <= send[1];
            code3_strobe <= send[2];
            code4_strobe <= send[3];
            code5_strobe <= send[4];
        end else if (finish) begin
            // Completion seen: withdraw every strobe
            code1_strobe <= 1'b0;
            code2_strobe <= 1'b0;
            code3_strobe <= 1'b0;
            code4_strobe <= 1'b0;
            code5_strobe <= 1'b0;
        end
    end
endmodule // pmo_port

// *** hw/pmo_regs.vh ***
`ifndef PMO_REGS_VH
`define PMO_REGS_VH
// Code word width, two's complement
`define PMO_CODE_W        32
// Number of code slots per block
`define PMO_SLOTS         5
// Largest magnitude in slot one
`define PMO_MAX_SLOT1     32'h3B9AC9FF
// Largest magnitude in slots two to five
`define PMO_MAX_SLOTN     32'h0000270F
// Subprogram call and return codes
`define PMO_CODE_CALL     32'h00000062
`define PMO_CODE_RETURN   32'h00000063
// State codes
`define PMO_ST_IDLE       2'h0
`define PMO_ST_WAIT       2'h1
`define PMO_ST_DROP       2'h2
`endif

// *** hw/pmo_slot_check.v ***
`timescale 1ns/1ns
`include "pmo_regs.vh"
// Judges one slot: in range and not a subprogram code
module pmo_slot_check #(
    parameter CODE_W = `PMO_CODE_W         // Bits in one code word
) (
    input  wire [CODE_W-1:0] code,         // Signed code value
    input  wire [CODE_W-1:0] max_mag,      // Largest allowed magnitude
    output wire              in_range,     // Magnitude within limit
    output wire              is_subprog    // Call or return code
);
    wire [CODE_W-1:0] mag;                 // Absolute value
    wire [CODE_W-1:0] one;                 // Constant one at word width

    assign one = {{(CODE_W-1){1'b0}}, 1'b1};
    // Negative codes are folded to their magnitude
    assign mag = code[CODE_W-1] ? (~code + one) : code;
    // Limit is inclusive; most negative word always fails
    assign in_range = (mag <= max_mag);
    // Call and return codes never reach the far side
    assign is_subprog = (code == `PMO_CODE_CALL) || (code == `PMO_CODE_RETURN);
endmodule // pmo_slot_check

// *** bench/pmo_port_sva.sv ***
`timescale 1ns/1ns
`include "pmo_regs.vh"
// Pin checks on the plural code port
module pmo_port_sva(input wire clock, arst_n, blk_ready, blk_error, busy, ops_complete,
    input wire code1_strobe, code2_strobe, code3_strobe, code4_strobe, code5_strobe,
    input wire [4:0] blk_used, input wire [159:0] blk_codes, input wire [31:0] code1_word);
    wire [4:0] stb = {code5_strobe, code4_strobe, code3_strobe, code2_strobe, code1_strobe};
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    sequence s_take; blk_ready && !blk_error; endsequence
    property p_pulse; blk_ready |=> !blk_ready; endproperty
    a_pulse: assert property (p_pulse) else $error("long ready");
    property p_used; s_take |-> (stb & ~$past(blk_used)) == 5'h00; endproperty
    a_used: assert property (p_used) else $error("stray strobe");
    property p_err; blk_ready && blk_error |-> stb == 5'h00; endproperty
    a_err: assert property (p_err) else $error("strobe on error");
    property p_word; s_take ##0 code1_strobe |-> code1_word == $past(blk_codes[31:0]);
    endproperty
    a_word: assert property (p_word) else $error("bad word");
    property p_hold; !blk_ready |-> $stable(code1_word); endproperty
    a_hold: assert property (p_hold) else $error("word moved");
    property p_sub; blk_ready && $past(blk_codes[31:0]) == `PMO_CODE_CALL |-> !code1_strobe;
    endproperty
    a_sub: assert property (p_sub) else $error("call strobed");
    property p_stand; |stb && !ops_complete |=> stb == $past(stb); endproperty
    a_stand: assert property (p_stand) else $error("strobe moved");
    property p_drop; |stb && ops_complete |=> stb == 5'h00; endproperty
    a_drop: assert property (p_drop) else $error("strobe stuck");
    property p_wait; $past(busy) |-> !blk_ready; endproperty
    a_wait: assert property (p_wait) else $error("taken while busy");
endmodule // pmo_port_sva

// *** bench/pmo_far.sv ***
`timescale 1ns/1ns
// Machine side: runs strobed ops for lag cycles, then completes
module pmo_far(input wire clock, input wire [4:0] stb, input wire [3:0] lag,
    output reg done = 1'b0);
    integer n = 0; // Cycles spent on the ops
    always @(posedge clock) begin
        if (stb == 5'h00) begin
            done <= 1'b0; // Drop once strobes are gone
            n <= 0;
        end else if (n < lag) n <= n + 1;
        else done <= 1'b1;
    end
endmodule // pmo_far

// *** bench/testbench.sv ***
`timescale 1ns/1ns
module testbench;
    reg clock = 1'b0, arst_n = 1'b0, blk_valid = 1'b0; // Clock, reset, offer
    reg [4:0] blk_used = 5'h00; // Slots commanded
    reg [159:0] blk_codes = 160'h0, v; // Offered codes, scratch
    reg [3:0] lag = 4'h0; // Far side delay
    integer bad_count = 0, n_compared = 0, cyc = 0; // Tallies
    wire [31:0] code1_word, code2_word, code3_word, code4_word, code5_word;
    wire code1_strobe, code2_strobe, code3_strobe, code4_strobe, code5_strobe;
    wire blk_ready, blk_error, ops_complete, busy;
    wire [159:0] w = {code5_word, code4_word, code3_word, code2_word, code1_word};
    wire [4:0] s = {code5_strobe, code4_strobe, code3_strobe, code2_strobe, code1_strobe};
    pmo_port dut(.clock(clock), .arst_n(arst_n), .blk_valid(blk_valid), .blk_used(blk_used),
        .blk_codes(blk_codes), .blk_ready(blk_ready), .blk_error(blk_error), .busy(busy),
        .code1_word(code1_word), .code2_word(code2_word), .code3_word(code3_word),
        .code4_word(code4_word), .code5_word(code5_word), .code1_strobe(code1_strobe),
        .code2_strobe(code2_strobe), .code3_strobe(code3_strobe),
        .code4_strobe(code4_strobe), .code5_strobe(code5_strobe),
        .ops_complete(ops_complete));
    pmo_far far(.clock(clock), .stb(s), .lag(lag), .done(ops_complete));
    initial forever #50 clock = ~clock;
    // Cut a hang short
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin
            bad_count = bad_count + 1;
            results;
        end
    end
    task chk(input [166:0] g, e); begin
        n_compared = n_compared + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    end endtask
    // Offer a block, hold until taken, check, wait until idle
    task send(input [4:0] u, input [159:0] c, input [165:0] e); begin
        @(negedge clock);
        blk_used = u;
        blk_codes = c;
        blk_valid = 1'b1;
        @(negedge clock);
        while (!blk_ready) @(negedge clock);
        blk_valid = 1'b0;
        chk({busy, blk_error, s, w}, {|e[164:160], e});
        while (busy) @(negedge clock);
    end endtask
    task s_five; begin // Slots one to three at range limits, far side at current lag
        v = {32'h0, 32'h1, 32'hFFFFD8F1, 32'h270F, 32'hC4653601};
        send(5'h1F, v, {1'b0, 5'h1F, v});
    end endtask
    task s_sub; begin // Call and return beside a real code, slow far side
        lag = 4'h9;
        v[95:0] = {32'h2A, 32'h63, 32'h62};
        send(5'h07, v, {1'b0, 5'h04, v[159:64], 32'h270F, 32'hC4653601});
        send(5'h01, 160'h63, {1'b0, 5'h00, v[159:64], 32'h270F, 32'hC4653601});
    end endtask
    task s_err; begin // Out of range codes leave words alone
        v[63:0] = {32'h270F, 32'hC4653601};
        send(5'h01, 160'h3B9ACA00, {1'b1, 5'h00, v});
        send(5'h02, 160'h2710 << 32, {1'b1, 5'h00, v});
    end endtask
    task s_rst; begin // Mid-run reset clears busy, error, strobes and words
        @(negedge clock);
        arst_n = 1'b0;
        @(negedge clock);
        chk({busy, blk_error, s, w}, 167'h0);
        arst_n = 1'b1;
    end endtask
    task results; begin
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    end endtask
    initial begin
        repeat (10) @(negedge clock);
        arst_n = 1'b1;
        s_five;
        s_sub;
        s_err;
        s_rst;
        s_five;
        results;
    end
endmodule // testbench
bind pmo_port pmo_port_sva u_sva(.clock(clock), .arst_n(arst_n), .blk_ready(blk_ready),
    .blk_error(blk_error), .busy(busy), .ops_complete(ops_complete),
    .code1_strobe(code1_strobe), .code2_strobe(code2_strobe), .code3_strobe(code3_strobe),
    .code4_strobe(code4_strobe), .code5_strobe(code5_strobe), .blk_used(blk_used),
    .blk_codes(blk_codes), .code1_word(code1_word));
